// ===== rtl/cmtc_defs.vh
// Constants for the coding-mode transition controller
`ifndef CMTC_DEFS_VH
`define CMTC_DEFS_VH

// Coding core codes
`define CMTC_CORE_PRED       2'h0
`define CMTC_CORE_TCX        2'h1
`define CMTC_CORE_HQ         2'h2

// Bit-rate codes
`define CMTC_RATE_7K2        3'h0
`define CMTC_RATE_8K0        3'h1
`define CMTC_RATE_9K6        3'h2
`define CMTC_RATE_13K2       3'h3
`define CMTC_RATE_16K4       3'h4
`define CMTC_RATE_24K4       3'h5
`define CMTC_RATE_32K        3'h6
`define CMTC_RATE_64K        3'h7

// Transition mode one-hot codes
`define CMTC_MODE_NONE       3'h0
`define CMTC_MODE_ONE        3'h1
`define CMTC_MODE_TWO        3'h2
`define CMTC_MODE_THREE      3'h4

// Transform sampling rate codes and rates in Hz
`define CMTC_SR_12K8         2'h0
`define CMTC_SR_16K          2'h1
`define CMTC_SR_25K6         2'h2
`define CMTC_SR_32K          2'h3
`define CMTC_HZ_12K8         12800
`define CMTC_HZ_16K          16000
`define CMTC_HZ_25K6         25600
`define CMTC_HZ_32K          32000

// Window timing in microseconds
`define CMTC_FRAME_US        20000
`define CMTC_RISE_US         1250
`define CMTC_FOLD_US         625
`define CMTC_LONG_US         25000
`define CMTC_US_PER_S        1000000

// Q15 values
`define CMTC_Q15_ONE         16'h7fff
`define CMTC_TILT_Q15        16'h2666
`define CMTC_TILT_ZERO       16'h0000
`define CMTC_Q15_SHIFT       15

// Recurrence seeds: sin(d/2), sin(3d/2), 2cos(d), d = pi/(2*Nt), Q24
// Q24 keeps drift under one output LSB; Q15 state drifts by tens of LSB
`define CMTC_S0_12K8         32'h000c8fb3
`define CMTC_S1_12K8         32'h00259021
`define CMTC_K_12K8          32'h01fd88da
`define CMTC_S0_16K          32'h000a0cee
`define CMTC_S1_16K          32'h001e16ee
`define CMTC_K_16K           32'h01fe6bf3
`define CMTC_S0_25K6         32'h00064855
`define CMTC_S1_25K6         32'h0012d521
`define CMTC_K_25K6          32'h01ff621e
`define CMTC_S0_32K          32'h000506b7
`define CMTC_S1_32K          32'h000f1228
`define CMTC_K_32K           32'h01ff9af3
`define CMTC_SINE_FRAC       24
`define CMTC_SINE_DROP       9

// Count widths
`define CMTC_CNT_W           10
`define CMTC_CNT_ZERO        10'h000
`define CMTC_CNT_ONE         10'h001

`endif

// ===== rtl/cmtc_sine_gen.v
// Rising sine window generator using a second-order recurrence
`timescale 1ns/1ps
`include "cmtc_defs.vh"
module cmtc_sine_gen (
   // Clock and reset
   input  wire        clk,
   input  wire        arst_n,
   // Control
   input  wire        load,
   input  wire        adv,
   input  wire [1:0]  sr_sel,
   // Window sample
   output wire [15:0] coef
);

   reg  signed [31:0] cur_s;     // Sample n, Q24
   reg  signed [31:0] nxt_s;     // Sample n+1, Q24
   reg  signed [31:0] k_coef;    // Twice cosine of step, Q24
   reg  signed [31:0] seed0;     // Chosen first seed
   reg  signed [31:0] seed1;     // Chosen second seed
   reg  signed [31:0] seedk;     // Chosen multiplier
   wire signed [63:0] prod;      // Full product
   wire signed [63:0] prod_q;    // Product back in Q24
   wire signed [31:0] next_s;    // Next recurrence value
   wire signed [31:0] cur_q15;   // Sample n in Q15

   // Seed select per transform rate
   always @* begin
      case (sr_sel)
         `CMTC_SR_12K8: begin
            seed0 = `CMTC_S0_12K8;
            seed1 = `CMTC_S1_12K8;
            seedk = `CMTC_K_12K8;
         end
         `CMTC_SR_16K: begin
            seed0 = `CMTC_S0_16K;
            seed1 = `CMTC_S1_16K;
            seedk = `CMTC_K_16K;
         end
         `CMTC_SR_25K6: begin
            seed0 = `CMTC_S0_25K6;
            seed1 = `CMTC_S1_25K6;
            seedk = `CMTC_K_25K6;
         end
         default: begin
            seed0 = `CMTC_S0_32K;
            seed1 = `CMTC_S1_32K;
            seedk = `CMTC_K_32K;
         end
      endcase
   end

   // sin((n+2)d) = 2cos(d) sin((n+1)d) - sin(nd); avoids a large table
   assign prod    = k_coef * nxt_s;
   assign prod_q  = prod >>> `CMTC_SINE_FRAC;
   assign next_s  = prod_q[31:0] - cur_s;
   assign cur_q15 = cur_s >>> `CMTC_SINE_DROP;

   // Recurrence state
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cur_s  <= 32'h00000000;
         nxt_s  <= 32'h00000000;
         k_coef <= 32'h00000000;
      end else if (load) begin
         cur_s  <= seed0;
         nxt_s  <= seed1;
         k_coef <= seedk;
      end else if (adv) begin
         cur_s  <= nxt_s;
         nxt_s  <= next_s;
      end
   end

   // Truncate to Q15 and clamp; drift stays under one LSB over 40 steps
   assign coef = (cur_q15 > $signed({16'h0000, `CMTC_Q15_ONE})) ? `CMTC_Q15_ONE :
                 (cur_q15[31] ? 16'h0000 : cur_q15[15:0]);

endmodule

// ===== rtl/cmtc_ctrl.v
// Frame-level controller for transform/predictive core transitions
//
// Overview of operation
// (RL1) Hq to predictive at listed rates: mode one
// (RL2) Tcx to predictive at 9.6/16.4/24.4: mode two
// (RL3) Hq to predictive at 16.4/24.4: mode three
// (RL4) Update predictive memories before encoding starts
// (RL5) Mode one clears synthesis, emphasis, excitation memories
// (RL6) Mode one presets coefficients, pairs, gain memories
// (RL7) Mode one forces transient coding type
// (RL8) Mode one codes one end set, all subframes
// (RL9) Mode two reuses memories; 9.6 recomputes unweighted
// (RL10) Mode two refreshes memories from internal decoder
// (RL11) Mode three resets state, tilt factor 0.3
// (RL12) Mode three uses non-predictive safety-net quantization
// (RL13) Mode three copies current end values to previous
// (RL14) Predictive to tcx: fold 0.625ms earlier, 25ms
// (RL15) Right window half keeps its normal shape
// (RL16) Left half: unit over frame, 1.25ms sine rise
// (RL17) Rise length 0.00125*rate, sine at n+0.5
// (RL18) Registered previous core, updated each frame boundary
`timescale 1ns/1ps
`include "cmtc_defs.vh"
module cmtc_ctrl (
   // Clock and reset
   input  wire        CLK,
   input  wire        ARST_N,
   // Frame sequencing
   input  wire        FRAME_START,
   input  wire [1:0]  CUR_CORE,
   input  wire [2:0]  RATE,
   input  wire [1:0]  SR_SEL,
   input  wire [1:0]  RIGHT_SHAPE_IN,
   // Transition decision
   output reg  [2:0]  TRANS_MODE,
   output reg  [1:0]  PREV_CORE,
   // Predictive memory operations, one-cycle strobes
   output reg         CLR_RESAMP_MEM,
   output reg         CLR_EMPH_MEM,
   output reg         CLR_SYNTH_MEM,
   output reg         CLR_EXC_MEM,
   output reg         PRESET_LPC_MEM,
   output reg         PRESET_GAIN_MEM,
   output reg         REUSE_QUANT_MEM,
   output reg         RECOMP_UNWEIGHTED,
   output reg         REFRESH_FROM_DEC,
   output reg         RESET_STATE,
   output reg         COPY_END_LSF,
   // Frame-long coding controls
   output reg         FORCE_TRANSIENT,
   output reg         SINGLE_LPC_SET,
   output reg         SAFETY_NET,
   output reg  [15:0] TILT_FACTOR,
   // Transform window controls
   output reg         LONG_TRANSFORM,
   output reg  [9:0]  FOLD_SHIFT,
   output reg  [1:0]  RIGHT_SHAPE,
   output reg         WIN_VALID,
   output reg  [15:0] WIN_COEF,
   // Encoding go
   output reg         ENC_GO
);

   // One-hot states
   localparam [4:0] ST_IDLE   = 5'h01;
   localparam [4:0] ST_DECIDE = 5'h02;
   localparam [4:0] ST_MEMOP  = 5'h04;
   localparam [4:0] ST_WIN    = 5'h08;
   localparam [4:0] ST_GO     = 5'h10;

   reg  [4:0]  state;            // Current state
   reg  [4:0]  next_state;       // Next state
   reg  [1:0]  cur_core;         // Core of this frame
   reg  [2:0]  rate;             // Rate of this frame
   reg  [1:0]  sr_sel;           // Transform rate of this frame
   reg  [2:0]  next_mode;        // Decoded transition mode
   reg  [9:0]  rise_len;         // Sine samples in this frame
   reg  [9:0]  frame_len;        // Unit samples in this frame
   reg  [9:0]  win_cnt;          // Window sample counter
   reg         in_rise;          // Window still in sine part
   reg         sine_load;        // Seed the sine generator
   reg         sine_adv;         // Step the sine generator
   wire [15:0] sine_coef;        // Current sine sample

   // Samples for a span at a transform rate
   function [9:0] span_len;
      input [1:0]  sel;
      input [31:0] us;
      reg   [31:0] hz;
      reg   [31:0] samples;
      begin
         case (sel)
            `CMTC_SR_12K8: hz = `CMTC_HZ_12K8;
            `CMTC_SR_16K:  hz = `CMTC_HZ_16K;
            `CMTC_SR_25K6: hz = `CMTC_HZ_25K6;
            default:       hz = `CMTC_HZ_32K;
         endcase
         samples  = (hz * us) / `CMTC_US_PER_S;
         span_len = samples[9:0];
      end
   endfunction

   // Transition mode from previous core, current core and rate
   function [2:0] pick_mode;
      input [1:0] prv;
      input [1:0] cur;
      input [2:0] rt;
      begin
         pick_mode = `CMTC_MODE_NONE;
         if (cur == `CMTC_CORE_PRED && prv == `CMTC_CORE_HQ) begin
            case (rt)
               `CMTC_RATE_16K4,
               `CMTC_RATE_24K4: pick_mode = `CMTC_MODE_THREE;  // RL3
               default:         pick_mode = `CMTC_MODE_ONE;    // RL1
            endcase
         end else if (cur == `CMTC_CORE_PRED && prv == `CMTC_CORE_TCX) begin
            case (rt)
               `CMTC_RATE_13K2,
               `CMTC_RATE_32K:  pick_mode = `CMTC_MODE_ONE;    // RL1
               default:         pick_mode = `CMTC_MODE_TWO;    // RL2
            endcase
         end
      end
   endfunction

   // Sine rise generator
   cmtc_sine_gen u_sine (
      .clk    (CLK),
      .arst_n (ARST_N),
      .load   (sine_load),
      .adv    (sine_adv),
      .sr_sel (sr_sel),
      .coef   (sine_coef)
   );

   // Frame capture and previous core register
   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         cur_core  <= `CMTC_CORE_PRED;
         PREV_CORE <= `CMTC_CORE_PRED;
         rate      <= `CMTC_RATE_7K2;
         sr_sel    <= `CMTC_SR_12K8;
      end else if (FRAME_START && state == ST_IDLE) begin
         PREV_CORE <= cur_core;  // RL18
         cur_core  <= CUR_CORE;
         rate      <= RATE;
         sr_sel    <= SR_SEL;
      end
   end

   // Mode decode from the registered cores
   always @* begin
      next_mode = pick_mode(PREV_CORE, cur_core, rate);  // RL18
   end

   // State sequencing
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE:   if (FRAME_START) next_state = ST_DECIDE;
         ST_DECIDE: begin
            // Predictive after transform: memories first
            if (next_mode != `CMTC_MODE_NONE)
               next_state = ST_MEMOP;  // RL4
            else if (cur_core == `CMTC_CORE_TCX && PREV_CORE == `CMTC_CORE_PRED)
               next_state = ST_WIN;
            else
               next_state = ST_GO;
         end
         ST_MEMOP:  next_state = ST_GO;  // RL4
         ST_WIN:    if (!in_rise && win_cnt == `CMTC_CNT_ONE) next_state = ST_GO;
         ST_GO:     next_state = ST_IDLE;
         default:   next_state = ST_IDLE;
      endcase
   end

   // State register
   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N)
         state <= ST_IDLE;
      else
         state <= next_state;
   end

   // Mode and frame-long coding controls
   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         TRANS_MODE      <= `CMTC_MODE_NONE;
         FORCE_TRANSIENT <= 1'b0;
         SINGLE_LPC_SET  <= 1'b0;
         SAFETY_NET      <= 1'b0;
         TILT_FACTOR     <= `CMTC_TILT_ZERO;
      end else if (state == ST_DECIDE) begin
         TRANS_MODE      <= next_mode;
         // No past excitation, so no adaptive codebook
         FORCE_TRANSIENT <= (next_mode == `CMTC_MODE_ONE);  // RL7
         // Previous coefficients absent: one end set for all subframes
         SINGLE_LPC_SET  <= (next_mode == `CMTC_MODE_ONE);  // RL8
         SAFETY_NET      <= (next_mode == `CMTC_MODE_THREE);  // RL12
         if (next_mode == `CMTC_MODE_THREE)
            TILT_FACTOR <= `CMTC_TILT_Q15;  // RL11
         else
            TILT_FACTOR <= `CMTC_TILT_ZERO;
      end
   end

   // Memory operation strobes, one cycle after the memory state
   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         CLR_RESAMP_MEM    <= 1'b0;
         CLR_EMPH_MEM      <= 1'b0;
         CLR_SYNTH_MEM     <= 1'b0;
         CLR_EXC_MEM       <= 1'b0;
         PRESET_LPC_MEM    <= 1'b0;
         PRESET_GAIN_MEM   <= 1'b0;
         REUSE_QUANT_MEM   <= 1'b0;
         RECOMP_UNWEIGHTED <= 1'b0;
         REFRESH_FROM_DEC  <= 1'b0;
         RESET_STATE       <= 1'b0;
         COPY_END_LSF      <= 1'b0;
      end else begin
         CLR_RESAMP_MEM    <= state == ST_MEMOP && TRANS_MODE == `CMTC_MODE_ONE;  // RL5
         CLR_EMPH_MEM      <= state == ST_MEMOP && TRANS_MODE == `CMTC_MODE_ONE;  // RL5
         CLR_SYNTH_MEM     <= state == ST_MEMOP && TRANS_MODE == `CMTC_MODE_ONE;  // RL5
         CLR_EXC_MEM       <= state == ST_MEMOP && TRANS_MODE == `CMTC_MODE_ONE;  // RL5
         PRESET_LPC_MEM    <= state == ST_MEMOP && TRANS_MODE == `CMTC_MODE_ONE;  // RL6
         PRESET_GAIN_MEM   <= state == ST_MEMOP && TRANS_MODE == `CMTC_MODE_ONE;  // RL6
         REUSE_QUANT_MEM   <= state == ST_MEMOP && TRANS_MODE == `CMTC_MODE_TWO;  // RL9
         // Weighted coefficients were quantized only at this rate
         RECOMP_UNWEIGHTED <= state == ST_MEMOP && TRANS_MODE == `CMTC_MODE_TWO
                              && rate == `CMTC_RATE_9K6;  // RL9
         REFRESH_FROM_DEC  <= state == ST_MEMOP && TRANS_MODE == `CMTC_MODE_TWO;  // RL10
         RESET_STATE       <= state == ST_MEMOP && TRANS_MODE == `CMTC_MODE_THREE;  // RL11
         COPY_END_LSF      <= state == ST_MEMOP && TRANS_MODE == `CMTC_MODE_THREE;  // RL13
      end
   end

   // Window geometry for the predictive-to-transform frame
   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         LONG_TRANSFORM <= 1'b0;
         FOLD_SHIFT     <= `CMTC_CNT_ZERO;
         RIGHT_SHAPE    <= 2'h0;
         rise_len       <= `CMTC_CNT_ZERO;
         frame_len      <= `CMTC_CNT_ZERO;
      end else if (state == ST_DECIDE) begin
         LONG_TRANSFORM <= (cur_core == `CMTC_CORE_TCX && PREV_CORE == `CMTC_CORE_PRED);  // RL14
         if (cur_core == `CMTC_CORE_TCX && PREV_CORE == `CMTC_CORE_PRED)
            FOLD_SHIFT <= span_len(sr_sel, `CMTC_FOLD_US);  // RL14
         else
            FOLD_SHIFT <= `CMTC_CNT_ZERO;
         // Right half passes through untouched
         RIGHT_SHAPE    <= RIGHT_SHAPE_IN;  // RL15
         rise_len       <= span_len(sr_sel, `CMTC_RISE_US);  // RL17
         frame_len      <= span_len(sr_sel, `CMTC_FRAME_US);  // RL16
      end
   end

   // Sine generator control, combinational from the state and rise flag
   always @* begin
      sine_load = (state == ST_DECIDE);
      sine_adv  = (state == ST_WIN) && in_rise;
   end

   // Left-half window stream: sine rise, then unit weight to the border
   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         win_cnt   <= `CMTC_CNT_ZERO;
         in_rise   <= 1'b0;
         WIN_VALID <= 1'b0;
         WIN_COEF  <= 16'h0000;
      end else if (state == ST_DECIDE) begin
         win_cnt   <= span_len(sr_sel, `CMTC_RISE_US);  // RL17
         in_rise   <= 1'b1;
         WIN_VALID <= 1'b0;
      end else if (state == ST_WIN) begin
         WIN_VALID <= 1'b1;
         if (in_rise) begin
            WIN_COEF <= sine_coef;  // RL17
            if (win_cnt == `CMTC_CNT_ONE) begin
               in_rise <= 1'b0;
               win_cnt <= frame_len;  // RL16
            end else begin
               win_cnt <= win_cnt - `CMTC_CNT_ONE;
            end
         end else begin
            WIN_COEF <= `CMTC_Q15_ONE;  // RL16
            win_cnt  <= win_cnt - `CMTC_CNT_ONE;
         end
      end else begin
         WIN_VALID <= 1'b0;
      end
   end

   // Encoder go after memories and window are settled
   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N)
         ENC_GO <= 1'b0;
      else
         ENC_GO <= (state == ST_GO);  // RL4
   end

endmodule

// ===== testbench/cmtc_ctrl_properties.sv
// Concurrent checks on the transition controller ports
`timescale 1ns/1ps
`include "cmtc_defs.vh"
module cmtc_ctrl_props (
   // Clock and reset
   input wire logic        CLK,
   input wire logic        ARST_N,
   // Decision and memory strobes
   input wire logic [2:0]  TRANS_MODE,
   input wire logic        CLR_RESAMP_MEM,
   input wire logic        CLR_EMPH_MEM,
   input wire logic        CLR_SYNTH_MEM,
   input wire logic        CLR_EXC_MEM,
   input wire logic        PRESET_LPC_MEM,
   input wire logic        PRESET_GAIN_MEM,
   input wire logic        REUSE_QUANT_MEM,
   input wire logic        RECOMP_UNWEIGHTED,
   input wire logic        REFRESH_FROM_DEC,
   input wire logic        RESET_STATE,
   input wire logic        COPY_END_LSF,
   // Frame-long controls
   input wire logic        FORCE_TRANSIENT,
   input wire logic        SINGLE_LPC_SET,
   input wire logic        SAFETY_NET,
   input wire logic [15:0] TILT_FACTOR,
   // Window and go
   input wire logic        LONG_TRANSFORM,
   input wire logic [9:0]  FOLD_SHIFT,
   input wire logic        WIN_VALID,
   input wire logic [15:0] WIN_COEF,
   input wire logic        ENC_GO
);
   // Single domain, so one clock and one disable for all
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!ARST_N);

   // Mode one clears and presets land in the same cycle
   sequence s_one_clear;
      CLR_RESAMP_MEM && CLR_EMPH_MEM && CLR_SYNTH_MEM && CLR_EXC_MEM;
   endsequence
   sequence s_one_preset;
      PRESET_LPC_MEM && PRESET_GAIN_MEM && TRANS_MODE == `CMTC_MODE_ONE;
   endsequence

   chk_one_strobes: assert property ((CLR_EXC_MEM || PRESET_LPC_MEM) |->
      (s_one_clear and s_one_preset) ##1 ENC_GO) else $error("mode one strobes out of step");
   chk_two_strobes: assert property ((REUSE_QUANT_MEM || RECOMP_UNWEIGHTED) |->
      REUSE_QUANT_MEM && REFRESH_FROM_DEC && TRANS_MODE == `CMTC_MODE_TWO ##1 ENC_GO)
      else $error("mode two strobes out of step");
   chk_three_strobes: assert property ((RESET_STATE || COPY_END_LSF) |->
      RESET_STATE && COPY_END_LSF && SAFETY_NET ##1 ENC_GO)
      else $error("mode three strobes out of step");
   chk_one_levels: assert property (FORCE_TRANSIENT == (TRANS_MODE == `CMTC_MODE_ONE)
      && SINGLE_LPC_SET == FORCE_TRANSIENT) else $error("mode one levels wrong");
   chk_three_levels: assert property (SAFETY_NET == (TRANS_MODE == `CMTC_MODE_THREE)
      && TILT_FACTOR == (SAFETY_NET ? `CMTC_TILT_Q15 : `CMTC_TILT_ZERO))
      else $error("mode three levels wrong");
   chk_mode_onehot: assert property ($onehot0(TRANS_MODE))
      else $error("mode code not one-hot");
   chk_fold_shift: assert property (LONG_TRANSFORM ?
      FOLD_SHIFT inside {10'h008, 10'h00a, 10'h010, 10'h014} : FOLD_SHIFT == 10'h000)
      else $error("fold shift wrong");
   chk_win_long: assert property (WIN_VALID |-> LONG_TRANSFORM && !TRANS_MODE)
      else $error("window outside long frame");
   chk_win_rise: assert property (WIN_VALID && $past(WIN_VALID) |->
      WIN_COEF >= $past(WIN_COEF)) else $error("window falls on left half");
   chk_go_after_win: assert property ($fell(WIN_VALID) |-> ENC_GO ##1 !ENC_GO)
      else $error("go not right after window");
   chk_go_pulse: assert property (ENC_GO |=> !ENC_GO)
      else $error("go longer than one cycle");
endmodule

bind cmtc_ctrl cmtc_ctrl_props i_cmtc_ctrl_props (.CLK(CLK), .ARST_N(ARST_N),
   .TRANS_MODE(TRANS_MODE), .CLR_RESAMP_MEM(CLR_RESAMP_MEM), .CLR_EMPH_MEM(CLR_EMPH_MEM),
   .CLR_SYNTH_MEM(CLR_SYNTH_MEM), .CLR_EXC_MEM(CLR_EXC_MEM), .PRESET_LPC_MEM(PRESET_LPC_MEM),
   .PRESET_GAIN_MEM(PRESET_GAIN_MEM), .REUSE_QUANT_MEM(REUSE_QUANT_MEM),
   .RECOMP_UNWEIGHTED(RECOMP_UNWEIGHTED), .REFRESH_FROM_DEC(REFRESH_FROM_DEC),
   .RESET_STATE(RESET_STATE), .COPY_END_LSF(COPY_END_LSF), .FORCE_TRANSIENT(FORCE_TRANSIENT),
   .SINGLE_LPC_SET(SINGLE_LPC_SET), .SAFETY_NET(SAFETY_NET), .TILT_FACTOR(TILT_FACTOR),
   .LONG_TRANSFORM(LONG_TRANSFORM), .FOLD_SHIFT(FOLD_SHIFT), .WIN_VALID(WIN_VALID),
   .WIN_COEF(WIN_COEF), .ENC_GO(ENC_GO));

// ===== testbench/cmtc_ctrl_tb.sv
// Self-checking bench for the transition controller
`timescale 1ns/1ps
`include "cmtc_defs.vh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
   $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module cmtc_ctrl_tb;
   // Stimulus
   logic        CLK, ARST_N, FRAME_START;
   logic [1:0]  CUR_CORE, SR_SEL, RIGHT_SHAPE_IN;
   logic [2:0]  RATE;
   // Observed outputs
   wire  [2:0]  TRANS_MODE;
   wire  [1:0]  PREV_CORE, RIGHT_SHAPE;
   wire         CLR_RESAMP_MEM, CLR_EMPH_MEM, CLR_SYNTH_MEM, CLR_EXC_MEM;
   wire         PRESET_LPC_MEM, PRESET_GAIN_MEM, REUSE_QUANT_MEM, RECOMP_UNWEIGHTED;
   wire         REFRESH_FROM_DEC, RESET_STATE, COPY_END_LSF, FORCE_TRANSIENT;
   wire         SINGLE_LPC_SET, SAFETY_NET, LONG_TRANSFORM, WIN_VALID, ENC_GO;
   wire  [15:0] TILT_FACTOR, WIN_COEF;
   wire  [9:0]  FOLD_SHIFT;
   // Bookkeeping and the bench's own view of the previous core
   int          fails, total_checks;
   logic [1:0]  prev;

   cmtc_ctrl i_cmtc_ctrl (.CLK(CLK), .ARST_N(ARST_N), .FRAME_START(FRAME_START),
      .CUR_CORE(CUR_CORE), .RATE(RATE), .SR_SEL(SR_SEL), .RIGHT_SHAPE_IN(RIGHT_SHAPE_IN),
      .TRANS_MODE(TRANS_MODE), .PREV_CORE(PREV_CORE), .CLR_RESAMP_MEM(CLR_RESAMP_MEM),
      .CLR_EMPH_MEM(CLR_EMPH_MEM), .CLR_SYNTH_MEM(CLR_SYNTH_MEM), .CLR_EXC_MEM(CLR_EXC_MEM),
      .PRESET_LPC_MEM(PRESET_LPC_MEM), .PRESET_GAIN_MEM(PRESET_GAIN_MEM),
      .REUSE_QUANT_MEM(REUSE_QUANT_MEM), .RECOMP_UNWEIGHTED(RECOMP_UNWEIGHTED),
      .REFRESH_FROM_DEC(REFRESH_FROM_DEC), .RESET_STATE(RESET_STATE),
      .COPY_END_LSF(COPY_END_LSF), .FORCE_TRANSIENT(FORCE_TRANSIENT),
      .SINGLE_LPC_SET(SINGLE_LPC_SET), .SAFETY_NET(SAFETY_NET), .TILT_FACTOR(TILT_FACTOR),
      .LONG_TRANSFORM(LONG_TRANSFORM), .FOLD_SHIFT(FOLD_SHIFT), .RIGHT_SHAPE(RIGHT_SHAPE),
      .WIN_VALID(WIN_VALID), .WIN_COEF(WIN_COEF), .ENC_GO(ENC_GO));

   // 25 MHz clock
   initial begin
      CLK = 1'b0;
      forever #20 CLK = ~CLK;
   end

   // Transform sampling rate in Hz for a rate code
   function automatic int hz_of(input logic [1:0] s);
      case (s)
         `CMTC_SR_12K8: hz_of = `CMTC_HZ_12K8;
         `CMTC_SR_16K:  hz_of = `CMTC_HZ_16K;
         `CMTC_SR_25K6: hz_of = `CMTC_HZ_25K6;
         default:       hz_of = `CMTC_HZ_32K;
      endcase
   endfunction

   // Expected transition mode from previous core, new core and rate
   function automatic logic [2:0] exp_mode(input logic [1:0] p, c, input logic [2:0] r);
      if (c != `CMTC_CORE_PRED || p == `CMTC_CORE_PRED) return `CMTC_MODE_NONE;
      if (p == `CMTC_CORE_HQ)
         return (r == `CMTC_RATE_16K4 || r == `CMTC_RATE_24K4) ? `CMTC_MODE_THREE : `CMTC_MODE_ONE;
      return (r == `CMTC_RATE_13K2 || r == `CMTC_RATE_32K) ?
         `CMTC_MODE_ONE : `CMTC_MODE_TWO;
   endfunction

   // One whole frame: request, watch until go, judge all outputs, RIGHT_SHAPE in window frames only
   task automatic do_frame(input logic [1:0] c, input logic [2:0] r, input logic [1:0] s, shp);
      int          k, n, go, nt, f, bad, want, got;
      logic [10:0] now, s3, sany, es;
      logic [2:0]  em;
      logic        win;
      real         w;
      em = exp_mode(prev, c, r);
      win = (prev == `CMTC_CORE_PRED && c == `CMTC_CORE_TCX);
      nt = hz_of(s) * `CMTC_RISE_US / `CMTC_US_PER_S;
      f = hz_of(s) * `CMTC_FRAME_US / `CMTC_US_PER_S;
      {k, n, go, bad, s3, sany} = '0;
      es = {{6{em == `CMTC_MODE_ONE}}, em == `CMTC_MODE_TWO,
            em == `CMTC_MODE_TWO && r == `CMTC_RATE_9K6, em == `CMTC_MODE_TWO,
            {2{em == `CMTC_MODE_THREE}}};
      @(negedge CLK);
      FRAME_START = 1'b1;
      CUR_CORE = c;
      RATE = r;
      SR_SEL = s;
      RIGHT_SHAPE_IN = shp;
      @(negedge CLK);
      FRAME_START = 1'b0;
      // Bounded watch; sampled 1 ns after each edge so updates have landed
      while (go == 0 && k < 2000) begin
         @(posedge CLK);
         #1;
         k++;
         now = {CLR_RESAMP_MEM, CLR_EMPH_MEM, CLR_SYNTH_MEM, CLR_EXC_MEM, PRESET_LPC_MEM,
                PRESET_GAIN_MEM, REUSE_QUANT_MEM, RECOMP_UNWEIGHTED, REFRESH_FROM_DEC,
                RESET_STATE, COPY_END_LSF};
         sany = sany | now;
         if (k == 2) s3 = now;
         if (WIN_VALID === 1'b1) begin
            // Rise samples against the exact sine, tolerance for recurrence error
            if (n < nt) begin
               w = $sin(3.14159265358979 / 2.0 * (n + 0.5) / nt) * 32768.0;
               want = (w > 32767.0) ? 32767 : int'(w);
               got = WIN_COEF;
               if (got - want > 8 || want - got > 8) bad++;
            end else if (WIN_COEF !== `CMTC_Q15_ONE) bad++;
            if (n == 0 && k != 2) bad++;
            n++;
         end
         if (ENC_GO === 1'b1) go = k;
      end
      `CHK(TRANS_MODE, em)
      `CHK(go, win ? 2 + nt + f : (em != `CMTC_MODE_NONE ? 3 : 2))
      `CHK(PREV_CORE, prev)
      `CHK(s3, es)
      `CHK(sany, es)
      `CHK({FORCE_TRANSIENT, SINGLE_LPC_SET}, {2{em == `CMTC_MODE_ONE}})
      `CHK({SAFETY_NET, TILT_FACTOR}, {em == `CMTC_MODE_THREE, (em == `CMTC_MODE_THREE) ?
         `CMTC_TILT_Q15 : `CMTC_TILT_ZERO})
      `CHK({LONG_TRANSFORM, FOLD_SHIFT}, {win, win ? 10'(nt / 2) : 10'h000})
      `CHK(n, win ? nt + f : 0)
      `CHK(bad, 0)
      if (win) `CHK(RIGHT_SHAPE, shp)
      prev = c;
   endtask

   // Outputs cleared while held in reset
   task automatic t_reset;
      `CHK({TRANS_MODE, PREV_CORE, WIN_VALID, ENC_GO, LONG_TRANSFORM}, 8'h00)
   endtask

   // Every rate after the high-quality core
   task automatic t_hq_to_pred;
      for (int r = 0; r < 8; r++) begin
         do_frame(`CMTC_CORE_HQ, 3'(r), 2'(r), 2'h0);
         do_frame(`CMTC_CORE_PRED, 3'(r), 2'h0, 2'h0);
      end
   endtask

   // Tcx after predictive gives the long window, then back to predictive
   task automatic t_tcx_to_pred;
      logic [2:0] rt [5];
      rt = '{`CMTC_RATE_9K6, `CMTC_RATE_13K2, `CMTC_RATE_16K4, `CMTC_RATE_24K4, `CMTC_RATE_32K};
      for (int i = 0; i < 5; i++) begin
         do_frame(`CMTC_CORE_TCX, rt[i], 2'(i), 2'(i + 1));
         do_frame(`CMTC_CORE_PRED, rt[i], 2'(i), 2'h0);
      end
   endtask

   // Transform to transform and predictive to predictive: nothing happens, until the last hq to predictive frame in mode one
   task automatic t_chain;
      do_frame(`CMTC_CORE_PRED, `CMTC_RATE_24K4, 2'h1, 2'h0);
      do_frame(`CMTC_CORE_HQ, `CMTC_RATE_64K, 2'h1, 2'h0);
      do_frame(`CMTC_CORE_TCX, `CMTC_RATE_64K, 2'h1, 2'h0);
      do_frame(`CMTC_CORE_HQ, `CMTC_RATE_64K, 2'h1, 2'h0);
      do_frame(`CMTC_CORE_PRED, `CMTC_RATE_64K, 2'h1, 2'h0);
   endtask

   // Reset in mid window must forget the tcx core
   task automatic t_mid_reset;
      @(negedge CLK);
      FRAME_START = 1'b1;
      CUR_CORE = `CMTC_CORE_TCX;
      SR_SEL = `CMTC_SR_32K;
      @(negedge CLK);
      FRAME_START = 1'b0;
      repeat (10) @(negedge CLK);
      ARST_N = 1'b0;
      #1;
      `CHK({WIN_VALID, LONG_TRANSFORM, TRANS_MODE, PREV_CORE}, 7'h00)
      repeat (2) @(negedge CLK);
      ARST_N = 1'b1;
      prev = `CMTC_CORE_PRED;
      do_frame(`CMTC_CORE_PRED, `CMTC_RATE_9K6, 2'h0, 2'h0);
   endtask

   // Verdict and end of run
   task automatic finish_test;
      if (fails == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Watchdog well beyond the longest expected run
   initial begin
      #(60000 * 40);
      fails++;
      finish_test;
   end

   // Main sequence
   initial begin
      {fails, total_checks} = '0;
      {ARST_N, FRAME_START, CUR_CORE, RATE, SR_SEL, RIGHT_SHAPE_IN} = '0;
      prev = `CMTC_CORE_PRED;
      repeat (16) @(negedge CLK);
      t_reset;
      ARST_N = 1'b1;
      t_hq_to_pred;
      t_tcx_to_pred;
      t_chain;
      t_mid_reset;
      finish_test;
   end
endmodule
